// ==== verilog/ati_params.svh ====
`ifndef ATI_PARAMS_SVH
`define ATI_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ATI_Z_LOW_ADDR       8'h2c
`define ATI_Z_HIGH_ADDR      8'h2d
`define ATI_ONE_CONFIG_ADDR  8'h30
`define ATI_ONE_SOURCE_ADDR  8'h31
`define ATI_ONE_THRESH_ADDR  8'h32
`define ATI_ONE_DUR_ADDR     8'h33
`define ATI_TWO_CONFIG_ADDR  8'h34
`define ATI_TWO_SOURCE_ADDR  8'h35
`define ATI_TWO_THRESH_ADDR  8'h36
`define ATI_TWO_DUR_ADDR     8'h37

// ****************************************
// Reset values and field layout
// ****************************************
`define ATI_CONFIG_RESET     8'h00
`define ATI_SOURCE_RESET     8'h00
`define ATI_THRESH_RESET     7'h00
`define ATI_DUR_RESET        7'h00
`define ATI_CONFIG_WMASK     8'hbf
`define ATI_VALUE_WIDTH      7
`define ATI_DUR_MAX          7'h7f
`define ATI_UNMAPPED_DATA    8'h00

`endif

// ==== verilog/ati_pkg.sv ====
package ati_pkg;

	// Per-generator configuration layout
	typedef struct packed {
		logic and_or_select;
		logic fixed_zero;
		logic z_above_enable;
		logic z_below_enable;
		logic y_above_enable;
		logic y_below_enable;
		logic x_above_enable;
		logic x_below_enable;
	} ati_config_t;

	// Per-generator source layout
	typedef struct packed {
		logic fixed_zero;
		logic interrupt_active;
		logic z_above_flag;
		logic z_below_flag;
		logic y_above_flag;
		logic y_below_flag;
		logic x_above_flag;
		logic x_below_flag;
	} ati_source_t;

	// One acceleration sample of all three axes
	typedef struct packed {
		logic [15:0] z;
		logic [15:0] y;
		logic [15:0] x;
	} ati_sample_t;

	// Pin routing codes
	typedef enum logic [1:0] {
		ATI_ROUTE_OWN   = 2'b00,
		ATI_ROUTE_BOTH  = 2'b01,
		ATI_ROUTE_READY = 2'b10,
		ATI_ROUTE_BOOT  = 2'b11
	} ati_route_t;

endpackage

// ==== verilog/ati_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ati_params.svh"

module ati_generator (
	input  wire logic                 clk,         // System clock
	input  wire logic                 rst_n,       // Async reset, low
	input  wire logic                 sample_tick, // One pulse per sample
	input  wire ati_pkg::ati_sample_t sample,      // Current sample
	input  wire ati_pkg::ati_config_t config_reg,  // Enables and mode
	input  wire logic [6:0]           threshold,   // Threshold value
	input  wire logic [6:0]           duration,    // Minimum duration
	input  wire logic                 latch_sel,   // Latch select
	input  wire logic                 source_read, // Source read pulse
	output ati_pkg::ati_source_t      source       // Source register
);

	// ****************************************
	// Comparison
	// ****************************************
	// Magnitude of the high byte keeps the 7-bit threshold meaningful
	function automatic logic [7:0] mag(input logic [15:0] v);
		logic [7:0] hb;
		hb = v[15:8];
		mag = hb[7] ? 8'(~hb + 8'h01) : hb;
	endfunction

	logic [5:0] hit;
	logic [5:0] enables;
	logic [5:0] events;
	logic       combined;
	logic       qualified;
	logic [6:0] dur_count;
	logic [6:0] next_dur_count;
	ati_pkg::ati_source_t next_source;

	// Raw high/low conditions per axis, ordered as the flags
	always_comb begin
		hit[5] = mag(sample.z) > {1'b0, threshold};
		hit[4] = mag(sample.z) < {1'b0, threshold};
		hit[3] = mag(sample.y) > {1'b0, threshold};
		hit[2] = mag(sample.y) < {1'b0, threshold};
		hit[1] = mag(sample.x) > {1'b0, threshold};
		hit[0] = mag(sample.x) < {1'b0, threshold};
		enables = config_reg[5:0];
		events = hit & enables;
		// AND needs at least one enable, else it would fire idle
		if (config_reg.and_or_select) begin
			combined = (enables != 6'h00) && (events == enables);
		end else begin
			combined = |events;
		end
	end

	// ****************************************
	// Duration and source
	// ****************************************
	// Counter steps per sample, so duration scales with data rate
	always_comb begin
		next_dur_count = dur_count;
		qualified = sample_tick && combined && (dur_count >= duration);
		if (sample_tick) begin
			if (!combined) begin
				next_dur_count = 7'h00;
			end else if (dur_count != `ATI_DUR_MAX) begin
				next_dur_count = dur_count + 7'h01;
			end
		end
		next_source = source;
		if (source_read) begin
			next_source.interrupt_active = 1'b0;
			if (latch_sel) begin
				next_source[5:0] = 6'h00;
			end
		end
		if (sample_tick && !latch_sel) begin
			next_source[5:0] = qualified ? events : 6'h00;
		end
		// Set wins over a read in the same cycle
		if (qualified) begin
			next_source.interrupt_active = 1'b1;
			if (latch_sel) begin
				next_source[5:0] = next_source[5:0] | events;
			end
		end
		next_source.fixed_zero = 1'b0;
	end

	// State registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dur_count <= 7'h00;
			source    <= `ATI_SOURCE_RESET;
		end else begin
			dur_count <= next_dur_count;
			source    <= next_source;
		end
	end

endmodule
`default_nettype wire

// ==== verilog/ati_pin_route.sv ====
`timescale 1ns/1ps
`default_nettype none

module ati_pin_route (
	input  wire logic              clk,        // System clock
	input  wire logic              rst_n,      // Async reset, low
	input  wire ati_pkg::ati_route_t route,     // Routing code
	input  wire logic              own_irq,    // Own generator
	input  wire logic              other_irq,  // Other generator
	input  wire logic              data_ready, // Data ready level
	input  wire logic              boot_busy,  // Boot running level
	output logic                   pin         // Interrupt pin level
);

	logic next_pin;

	// Select the pin source
	always_comb begin
		unique case (route)
			ati_pkg::ATI_ROUTE_OWN:   next_pin = own_irq;
			ati_pkg::ATI_ROUTE_BOTH:  next_pin = own_irq | other_irq;
			ati_pkg::ATI_ROUTE_READY: next_pin = data_ready;
			ati_pkg::ATI_ROUTE_BOOT:  next_pin = boot_busy;
		endcase
	end

	// Registered so the pin never glitches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin <= 1'b0;
		end else begin
			pin <= next_pin;
		end
	end

endmodule
`default_nettype wire

// ==== verilog/ati_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ati_params.svh"

module ati_top (
	input  wire logic        CLK,             // 125 MHz clock
	input  wire logic        RST_N,           // Async reset, low
	input  wire logic        SAMPLE_VALID,    // New sample pulse
	input  wire logic [15:0] SAMPLE_X,        // X acceleration
	input  wire logic [15:0] SAMPLE_Y,        // Y acceleration
	input  wire logic [15:0] SAMPLE_Z,        // Z acceleration
	input  wire logic        DATA_READY,      // Data ready level
	input  wire logic        BOOT_RUNNING,    // Boot running level
	input  wire logic        LATCH_SELECT_ONE, // Latch for one
	input  wire logic        LATCH_SELECT_TWO, // Latch for two
	input  wire logic [1:0]  PIN_ONE_ROUTING, // Pin one source
	input  wire logic [1:0]  PIN_TWO_ROUTING, // Pin two source
	input  wire logic [7:0]  REG_ADDR,        // Register address
	input  wire logic        REG_WR,          // Write strobe
	input  wire logic [7:0]  REG_WDATA,       // Write data
	input  wire logic        REG_RD,          // Read strobe
	output logic      [7:0]  REG_RDATA,       // Read data
	output logic             REG_RVALID,      // Read data valid
	output logic             INT_ONE,         // First interrupt pin
	output logic             INT_TWO          // Second interrupt pin
);

	// ****************************************
	// Declarations
	// ****************************************
	ati_pkg::ati_sample_t sample;
	ati_pkg::ati_sample_t next_sample;
	ati_pkg::ati_config_t cfg_one;
	ati_pkg::ati_config_t cfg_two;
	ati_pkg::ati_config_t next_cfg_one;
	ati_pkg::ati_config_t next_cfg_two;
	ati_pkg::ati_source_t src_one;
	ati_pkg::ati_source_t src_two;
	logic [6:0] thr_one;
	logic [6:0] thr_two;
	logic [6:0] dur_one;
	logic [6:0] dur_two;
	logic [6:0] next_thr_one;
	logic [6:0] next_thr_two;
	logic [6:0] next_dur_one;
	logic [6:0] next_dur_two;
	logic       tick;
	logic       next_tick;
	logic       read_one;
	logic       read_two;
	logic [7:0] next_rdata;
	logic       next_rvalid;

	// Address match shared by reads and writes
	function automatic logic hit(
		input logic [7:0] addr,
		input logic [7:0] target
	);
		hit = (addr == target);
	endfunction

	// Config write keeps the fixed-zero bit clear
	function automatic ati_pkg::ati_config_t cfg_wr(
		input logic [7:0] data
	);
		cfg_wr = ati_pkg::ati_config_t'(data & `ATI_CONFIG_WMASK);
	endfunction

	// ****************************************
	// Sample capture
	// ****************************************
	// Samples arrive from logic on the same clock
	// A tick lines up with the captured sample one cycle later
	always_comb begin
		next_sample = sample;
		next_tick = SAMPLE_VALID;
		if (SAMPLE_VALID) begin
			next_sample.x = SAMPLE_X;
			next_sample.y = SAMPLE_Y;
			next_sample.z = SAMPLE_Z;
		end
	end

	// Sample registers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sample <= '0;
			tick   <= 1'b0;
		end else begin
			sample <= next_sample;
			tick   <= next_tick;
		end
	end

	// ****************************************
	// Writable registers
	// ****************************************
	// Source addresses are absent here, so writes there do nothing
	always_comb begin
		next_cfg_one = cfg_one;
		next_cfg_two = cfg_two;
		next_thr_one = thr_one;
		next_thr_two = thr_two;
		next_dur_one = dur_one;
		next_dur_two = dur_two;
		if (REG_WR) begin
			if (hit(REG_ADDR, `ATI_ONE_CONFIG_ADDR)) begin
				next_cfg_one = cfg_wr(REG_WDATA);
			end
			if (hit(REG_ADDR, `ATI_TWO_CONFIG_ADDR)) begin
				next_cfg_two = cfg_wr(REG_WDATA);
			end
			if (hit(REG_ADDR, `ATI_ONE_THRESH_ADDR)) begin
				next_thr_one = REG_WDATA[6:0];
			end
			if (hit(REG_ADDR, `ATI_TWO_THRESH_ADDR)) begin
				next_thr_two = REG_WDATA[6:0];
			end
			if (hit(REG_ADDR, `ATI_ONE_DUR_ADDR)) begin
				next_dur_one = REG_WDATA[6:0];
			end
			if (hit(REG_ADDR, `ATI_TWO_DUR_ADDR)) begin
				next_dur_two = REG_WDATA[6:0];
			end
		end
	end

	// Configuration registers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_one <= `ATI_CONFIG_RESET;
			cfg_two <= `ATI_CONFIG_RESET;
			thr_one <= `ATI_THRESH_RESET;
			thr_two <= `ATI_THRESH_RESET;
			dur_one <= `ATI_DUR_RESET;
			dur_two <= `ATI_DUR_RESET;
		end else begin
			cfg_one <= next_cfg_one;
			cfg_two <= next_cfg_two;
			thr_one <= next_thr_one;
			thr_two <= next_thr_two;
			dur_one <= next_dur_one;
			dur_two <= next_dur_two;
		end
	end

	// ****************************************
	// Source read side effects
	// ****************************************
	// A read pulse acknowledges the generator it addresses
	assign read_one = REG_RD && hit(REG_ADDR, `ATI_ONE_SOURCE_ADDR);
	assign read_two = REG_RD && hit(REG_ADDR, `ATI_TWO_SOURCE_ADDR);

	// ****************************************
	// Generators
	// ****************************************
	// Two independent copies, each with its own registers
	ati_generator u_gen_one (
		.clk         (CLK),
		.rst_n       (RST_N),
		.sample_tick (tick),
		.sample      (sample),
		.config_reg  (cfg_one),
		.threshold   (thr_one),
		.duration    (dur_one),
		.latch_sel   (LATCH_SELECT_ONE),
		.source_read (read_one),
		.source      (src_one)
	);

	// Second generator
	ati_generator u_gen_two (
		.clk         (CLK),
		.rst_n       (RST_N),
		.sample_tick (tick),
		.sample      (sample),
		.config_reg  (cfg_two),
		.threshold   (thr_two),
		.duration    (dur_two),
		.latch_sel   (LATCH_SELECT_TWO),
		.source_read (read_two),
		.source      (src_two)
	);

	// ****************************************
	// Read data
	// ****************************************
	// Data shows the source as it stood before the clearing edge
	always_comb begin
		next_rvalid = REG_RD;
		next_rdata = REG_RDATA;
		if (REG_RD) begin
			unique case (REG_ADDR)
				`ATI_Z_LOW_ADDR:      next_rdata = sample.z[7:0];
				`ATI_Z_HIGH_ADDR:     next_rdata = sample.z[15:8];
				`ATI_ONE_CONFIG_ADDR: next_rdata = cfg_one;
				`ATI_ONE_SOURCE_ADDR: next_rdata = src_one;
				`ATI_ONE_THRESH_ADDR: next_rdata = {1'b0, thr_one};
				`ATI_ONE_DUR_ADDR:    next_rdata = {1'b0, dur_one};
				`ATI_TWO_CONFIG_ADDR: next_rdata = cfg_two;
				`ATI_TWO_SOURCE_ADDR: next_rdata = src_two;
				`ATI_TWO_THRESH_ADDR: next_rdata = {1'b0, thr_two};
				`ATI_TWO_DUR_ADDR:    next_rdata = {1'b0, dur_two};
				default:              next_rdata = `ATI_UNMAPPED_DATA;
			endcase
		end
	end

	// Read data registers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RDATA  <= next_rdata;
			REG_RVALID <= next_rvalid;
		end
	end

	// ****************************************
	// Pin routing
	// ****************************************
	// Under codes 00 and 01, pins follow the active flags, cleared by a source read
	ati_pin_route u_route_one (
		.clk        (CLK),
		.rst_n      (RST_N),
		.route      (ati_pkg::ati_route_t'(PIN_ONE_ROUTING)),
		.own_irq    (src_one.interrupt_active),
		.other_irq  (src_two.interrupt_active),
		.data_ready (DATA_READY),
		.boot_busy  (BOOT_RUNNING),
		.pin        (INT_ONE)
	);

	// Second pin, code 01 still means the OR of both
	ati_pin_route u_route_two (
		.clk        (CLK),
		.rst_n      (RST_N),
		.route      (ati_pkg::ati_route_t'(PIN_TWO_ROUTING)),
		.own_irq    (src_two.interrupt_active),
		.other_irq  (src_one.interrupt_active),
		.data_ready (DATA_READY),
		.boot_busy  (BOOT_RUNNING),
		.pin        (INT_TWO)
	);

endmodule
`default_nettype wire

// ==== dv/ati_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Register host
// ****
module ati_host (
	input  wire logic       clk,    // Clock
	input  wire logic [7:0] rdata,  // Read data
	input  wire logic       rvalid, // Read valid
	output logic      [7:0] addr,   // Address
	output logic            wr,     // Write pulse
	output logic      [7:0] wdata,  // Write data
	output logic            rd      // Read pulse
);
	// Idle bus, strobes low
	initial begin
		addr = 8'h00;
		wr = 1'b0;
		wdata = 8'h00;
		rd = 1'b0;
	end
	// One write, taken at a single edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		wdata = ~d; // Stale data never looks valid
	endtask
	// One pulse only: a held strobe would clear a source twice
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		int n;
		@(posedge clk);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		n = 0;
		while (rvalid !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		d = rdata;
		ok = n < 4;
	endtask
endmodule
`default_nettype wire

// ==== dv/ati_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Pin and readback checks
// ****
module ati_chk (
	input wire logic       CLK,             // Clock
	input wire logic       RST_N,           // Reset, low
	input wire logic       SAMPLE_VALID,    // Sample pulse
	input wire logic       DATA_READY,      // Ready level
	input wire logic       BOOT_RUNNING,    // Boot level
	input wire logic [1:0] PIN_ONE_ROUTING, // Pin one code
	input wire logic [1:0] PIN_TWO_ROUTING, // Pin two code
	input wire logic [7:0] REG_ADDR,        // Address
	input wire logic       REG_RD,          // Read pulse
	input wire logic [7:0] REG_RDATA,       // Read data
	input wire logic       INT_ONE,         // Pin one
	input wire logic       INT_TWO          // Pin two
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// A late sample may win over the clear, so it is excluded
	a_one_read_clear: assert property (
		REG_RD && REG_ADDR == 8'h31 && !$past(SAMPLE_VALID) && PIN_ONE_ROUTING == 2'b00
		##1 PIN_ONE_ROUTING == 2'b00 |=> !INT_ONE) else $error("pin one high after read");
	a_two_read_clear: assert property (
		REG_RD && REG_ADDR == 8'h35 && !$past(SAMPLE_VALID) && PIN_TWO_ROUTING == 2'b00
		##1 PIN_TWO_ROUTING == 2'b00 |=> !INT_TWO) else $error("pin two high after read");
	a_src_top_zero: assert property (
		REG_RD && REG_ADDR inside {8'h31, 8'h35} |=> !REG_RDATA[7]) else $error("source bit 7");
	a_thr_top_zero: assert property (
		REG_RD && REG_ADDR inside {8'h32, 8'h33} |=> !REG_RDATA[7]) else $error("value bit 7");
	a_cfg_bit_zero: assert property (
		REG_RD && REG_ADDR inside {8'h30, 8'h34} |=> !REG_RDATA[6]) else $error("config bit 6");
	a_pin_ready: assert property (
		PIN_ONE_ROUTING == 2'b10 |=> INT_ONE == $past(DATA_READY)) else $error("ready route");
	a_pin_boot: assert property (
		PIN_TWO_ROUTING == 2'b11 |=> INT_TWO == $past(BOOT_RUNNING)) else $error("boot route");
	// Own-route rise needs a sample three edges back
	a_irq_after_sample: assert property (
		$rose(INT_ONE) && $past(PIN_ONE_ROUTING) == 2'b00 && $past(PIN_ONE_ROUTING, 2) == 2'b00
		|-> $past(SAMPLE_VALID, 3)) else $error("pin one rose without sample");
	c_one_read: cover property (REG_RD && REG_ADDR == 8'h31);
	c_irq_rise: cover property ($rose(INT_ONE));
	c_pin_or: cover property (PIN_ONE_ROUTING == 2'b01 && INT_ONE);
endmodule
bind ati_top ati_chk i_chk (.CLK(CLK), .RST_N(RST_N), .SAMPLE_VALID(SAMPLE_VALID),
	.DATA_READY(DATA_READY), .BOOT_RUNNING(BOOT_RUNNING), .PIN_ONE_ROUTING(PIN_ONE_ROUTING),
	.PIN_TWO_ROUTING(PIN_TWO_ROUTING), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .INT_ONE(INT_ONE), .INT_TWO(INT_TWO));
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Motion interrupt bench
// ****
module tb;
	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	logic            sv = 1'b0;
	logic [15:0]     sx = 16'h0000;
	logic [15:0]     sy = 16'h0000;
	logic [15:0]     sz = 16'h0000;
	logic            dr = 1'b0;
	logic            boot = 1'b0;
	logic            lat1 = 1'b0;
	logic            lat2 = 1'b0;
	logic [1:0]      rt1 = 2'h0;
	logic [1:0]      rt2 = 2'h0;
	logic [31:0]     seed = 32'h1;
	wire logic [7:0] addr, wdata, rdata;
	wire logic       wr, rd, rvalid, int1, int2;
	int              err_count = 0;
	int              samples_checked = 0;

	always #4 clk = ~clk;

	ati_top i_dut (.CLK(clk), .RST_N(rst_n), .SAMPLE_VALID(sv), .SAMPLE_X(sx), .SAMPLE_Y(sy),
		.SAMPLE_Z(sz), .DATA_READY(dr), .BOOT_RUNNING(boot), .LATCH_SELECT_ONE(lat1),
		.LATCH_SELECT_TWO(lat2), .PIN_ONE_ROUTING(rt1), .PIN_TWO_ROUTING(rt2),
		.REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
		.REG_RVALID(rvalid), .INT_ONE(int1), .INT_TWO(int2));
	ati_host i_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr), .wr(wr),
		.wdata(wdata), .rd(rd));

	// Xorshift, fixed start for repeatable runs
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// High byte magnitude, 80h counts as 128
	function automatic int mag(input logic [15:0] v);
		return v[15] ? 256 - int'(v[15:8]) : int'(v[15:8]);
	endfunction
	// Source for one fresh sample; equal to threshold is no event
	function automatic logic [7:0] exp_src(input logic [7:0] c, input logic [6:0] t,
		input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
		logic [5:0] hit;
		hit = c[5:0] & {mag(z) > t, mag(z) < t, mag(y) > t, mag(y) < t, mag(x) > t, mag(x) < t};
		if (c[7] ? (c[5:0] != 6'h00 && hit == c[5:0]) : hit != 6'h00)
			return {2'b01, hit};
		return 8'h00;
	endfunction
	function automatic logic exp_pin(input logic [1:0] c, input logic own, input logic oth);
		case (c)
			2'b00: return own;
			2'b01: return own | oth;
			2'b10: return dr;
			default: return boot;
		endcase
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp_reg(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		i_host.rd_reg(a, d, ok);
		samples_checked++;
		if (d !== e || ok !== 1'b1) begin
			$display("[ERR] reg %h exp %h got %h", a, e, d);
			err_count++;
		end
		if (ok !== 1'b1)
			stop_test();
	endtask
	task automatic cmp_pin(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %s exp %b got %b", n, e, g);
			err_count++;
		end
	endtask
	// Sample pulse, then wait until the pin has followed
	task automatic send(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z,
		input int gap);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		#1;
		{sv, sx, sy, sz} = {1'b1, x, y, z};
		@(posedge clk);
		#1;
		sv = 1'b0;
		{sx, sy, sz} = ~{x, y, z};
		repeat (2) @(posedge clk);
		#1;
	endtask

	initial begin
		logic [7:0]  c1, c2, e1, e2;
		logic [6:0]  t1, t2;
		logic [15:0] x, y, z;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		for (int a = 8'h30; a < 8'h36; a++)
			cmp_reg(8'(a), 8'h00);
		cmp_reg(8'h40, 8'h00);
		for (int a = 8'h30; a < 8'h36; a++)
			i_host.wr_reg(8'(a), 8'hff);
		cmp_reg(8'h30, 8'hbf);
		cmp_reg(8'h31, 8'h00);
		cmp_reg(8'h32, 8'h7f);
		cmp_reg(8'h33, 8'h7f);
		cmp_reg(8'h35, 8'h00);
		i_host.wr_reg(8'h30, 8'h00);
		cmp_reg(8'h34, 8'hbf);
		i_host.wr_reg(8'h33, 8'h00);
		$display("access test done");
		// Random settings; corners: 80h high byte, AND mode, equal threshold
		for (int i = 0; i < 40; i++) begin
			c1 = 8'(rnd()) & 8'hbf;
			c2 = 8'(rnd()) & 8'hbf;
			t1 = 7'(rnd());
			t2 = 7'(rnd());
			{x, y, z} = 48'({rnd(), rnd()});
			if (i == 0)
				{c1, t1, z} = {8'h20, 7'h7f, 16'h8000};
			if (i == 1)
				{c1, t1, x, y} = {8'h89, 7'h10, 16'h0f00, 16'hef00};
			if (i == 2)
				{c1, t1, z} = {8'h30, 7'h20, 16'he000};
			i_host.wr_reg(8'h30, c1);
			i_host.wr_reg(8'h32, {1'b0, t1});
			i_host.wr_reg(8'h34, c2);
			i_host.wr_reg(8'h36, {1'b0, t2});
			e1 = exp_src(c1, t1, x, y, z);
			e2 = exp_src(c2, t2, x, y, z);
			send(x, y, z, i % 3);
			cmp_pin("int1", e1[6], int1);
			cmp_pin("int2", e2[6], int2);
			cmp_reg(8'h31, e1);
			cmp_reg(8'h35, e2);
			cmp_reg(8'h2c, z[7:0]);
			cmp_reg(8'h2d, z[15:8]);
			cmp_pin("int1", 1'b0, int1);
			cmp_pin("int2", 1'b0, int2);
		end
		$display("random test done");
		// Duration two, uneven gaps: fires on the third held sample only
		i_host.wr_reg(8'h30, 8'h20);
		i_host.wr_reg(8'h32, 8'h10);
		i_host.wr_reg(8'h33, 8'h02);
		i_host.wr_reg(8'h34, 8'h00);
		// Quiet sample first, so no held count from the random run carries over
		send(16'h0000, 16'h0000, 16'h0000, 0);
		for (int i = 0; i < 6; i++) begin
			send(16'h0000, 16'h0000, i == 3 ? 16'h0000 : 16'h3000, 4 * i);
			cmp_pin("int1", i == 2, int1);
			if (i == 2)
				cmp_reg(8'h31, 8'h60);
		end
		$display("duration test done");
		{lat1, lat2} = 2'b11;
		i_host.wr_reg(8'h33, 8'h00);
		i_host.wr_reg(8'h34, 8'h01);
		i_host.wr_reg(8'h36, 8'h10);
		send(16'h0000, 16'h0000, 16'h3000, 0);
		send(16'h3000, 16'h0000, 16'h0000, 0);
		cmp_reg(8'h31, 8'h60);
		cmp_reg(8'h35, 8'h41);
		cmp_reg(8'h31, 8'h00);
		cmp_reg(8'h35, 8'h00);
		$display("latch test done");
		{lat1, lat2} = 2'b00;
		send(16'h0000, 16'h0000, 16'h0000, 0);
		for (int i = 0; i < 8; i++) begin
			{rt1, rt2} = {2'(i), 2'(i)};
			{dr, boot} = i[2] ? 2'b01 : 2'b10;
			repeat (2) @(posedge clk);
			#1;
			cmp_pin("int1", exp_pin(2'(i), 1'b0, 1'b1), int1);
			cmp_pin("int2", exp_pin(2'(i), 1'b1, 1'b0), int2);
		end
		{rt1, rt2} = 4'h0;
		cmp_reg(8'h35, 8'h41);
		$display("routing test done");
		stop_test();
	end
endmodule
`default_nettype wire
